// ---- bench/cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module cpu_model
  import wdt_pkg::*;
(
  input  wire logic              clk,
  output logic [ADDR_W-1:0]      s_axi_awaddr,
  output logic                   s_axi_awvalid,
  input  wire logic              s_axi_awready,
  output logic [31:0]            s_axi_wdata,
  output logic [3:0]             s_axi_wstrb,
  output logic                   s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  output logic                   s_axi_bready,
  output logic [ADDR_W-1:0]      s_axi_araddr,
  output logic                   s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [31:0]       s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  output logic                   s_axi_rready
);
  // ==========================================================
  // bus master; released address and data are inverted so stale values never match
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] rs);
    logic aw;
    logic w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1 && !aw) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr <= ~a;
      end
      if (s_axi_wready === 1'b1 && !w) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata <= ~d;
      end
    end
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench
  import wdt_pkg::*;
;
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0]       s_axi_wdata, s_axi_rdata, v;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic              s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic              hw_reset_req, reset_indication_output_n;
  logic [7:0]        rl;
  int                bad_count = 0, num_checks = 0, seed = 32'h011a, c;
  always #5 clk = ~clk;
  fail_safe_watchdog_timer u_dut (.*);
  cpu_model u_cpu (.*);
  // ==========================================================
  // helpers
  function automatic int div_of(input logic [1:0] s);
    return s[1] ? (s[0] ? 256 : 128) : (s[0] ? 4 : 2);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    u_cpu.rd(a, v, r);
    chk(v, e);
  endtask
  task automatic cmd(input int b);
    u_cpu.wr(OFS_CMD, 32'h1 << b, r);
  endtask
  task automatic do_reset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
  endtask
  task automatic ovf(input logic [1:0] s);
    u_cpu.wr(OFS_CTRL, 32'hFF00 | (32'(s) << CTRL_PSEL_LSB), r);
    cmd(CMD_SERVICE_BIT);
    c = 0;
    while (hw_reset_req !== 1'b1 && c < 70000) begin
      @(posedge clk);
      c++;
    end
    chk(32'(c >= 256 * div_of(s) - 4 && c <= 256 * div_of(s) + 8), 32'h1);
    @(posedge clk);
    chk(32'(reset_indication_output_n), 32'h0);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // tests
  initial begin
    #800000;
    bad_count++;
    finish_test;
  end
  initial begin
    do_reset;
    repeat (20) @(posedge clk);
    rchk(OFS_STATUS, 32'h1);
    rchk(OFS_CTRL, 32'h0);
    u_cpu.rd(OFS_COUNT, v, r);
    chk(32'(v != 0), 32'h1);
    cmd(CMD_DISABLE_BIT);
    u_cpu.rd(OFS_COUNT, v, r);
    repeat (20) @(posedge clk);
    rchk(OFS_COUNT, v);
    rchk(OFS_STATUS, 32'h0);
    $display("test early disable done");
    do_reset;
    cmd(CMD_INIT_END_BIT);
    @(posedge clk);
    chk(32'(reset_indication_output_n), 32'h1);
    cmd(CMD_DISABLE_BIT);
    rchk(OFS_STATUS, 32'h3);
    $display("test late disable done");
    for (int i = 0; i < 6; i++) begin
      rl = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($random(seed));
      u_cpu.wr(OFS_CTRL, 32'(rl) << CTRL_RELOAD_LSB, r);
      chk(32'(r), 32'(RESP_OKAY));
      cmd(CMD_SERVICE_BIT);
      u_cpu.rd(OFS_COUNT, v, r);
      chk(32'(v[15:8]), 32'(rl));
      chk(32'(v[7:0] < 8'h04), 32'h1);
    end
    $display("test reload done");
    for (int s = 0; s < 3; s++) ovf(2'(s));
    rchk(OFS_STATUS, 32'h5);
    u_cpu.wr(OFS_CTRL, 32'hFF06, r);
    cmd(CMD_SERVICE_BIT);
    repeat (1024) @(posedge clk);
    rchk(OFS_COUNT, 32'hFF00 | 32'(1024 / div_of(2'h3)));
    $display("test overflow done");
    do_reset;
    u_cpu.wr(OFS_CTRL, 32'h1, r);
    cmd(CMD_INIT_END_BIT);
    cmd(CMD_DISABLE_BIT);
    rchk(OFS_STATUS, 32'hA);
    cmd(CMD_ENABLE_BIT);
    rchk(OFS_STATUS, 32'hB);
    u_cpu.rd(4'h2, v, r);
    chk(32'(r), 32'(RESP_SLVERR));
    u_cpu.wr(4'h2, 32'h0, r);
    chk(32'(r), 32'(RESP_SLVERR));
    $display("test enhanced done");
    finish_test;
  end
endmodule
`default_nettype wire

// ---- bench/wdt_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module wdt_monitor (
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        hw_reset_req,
  input wire logic        reset_indication_output_n
);
  // ==========================================================
  // saturating gap since the last request, so the first one always fits
  logic [9:0] gap_r;
  logic [9:0] gap_nxt;
  always_comb gap_nxt = hw_reset_req ? 10'h000 : gap_r + {9'h000, gap_r != 10'h3FF};
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) gap_r <= 10'h3FF;
    else gap_r <= gap_nxt;
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  req_pulse_a: assert property (hw_reset_req |=> !hw_reset_req)
    else $error("reset request wider than one cycle");
  ind_low_a: assert property (hw_reset_req |-> ##[0:1] !reset_indication_output_n)
    else $error("reset indication not pulled low");
  gap_min_a: assert property (hw_reset_req |-> gap_r >= 10'h1F0)
    else $error("overflow sooner than shortest interval");
  ind_rise_a: assert property ($rose(reset_indication_output_n) |-> s_axi_bvalid
    || $past(s_axi_bvalid)) else $error("indication released without a write");
  wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[2:3] s_axi_bvalid) else $error("write response late");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while data pending");
  ovf_c: cover property (hw_reset_req);
  rd_c: cover property (s_axi_rvalid);
  wr_c: cover property (s_axi_bvalid);
endmodule
bind fail_safe_watchdog_timer wdt_monitor u_mon (.*);
`default_nettype wire

// ---- logic/fail_safe_watchdog_timer.sv ----
// Design decisions made here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module fail_safe_watchdog_timer
  import wdt_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   hw_reset_req,
  output logic                   reset_indication_output_n
);

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic              have_aw;
    logic              have_w;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic [15:0]       cnt;
    logic              enabled;
    logic              init_done;
    logic              enh_mode;
    logic [1:0]        psel;
    logic [7:0]        supervisor_reload_value;
    logic              ovf_seen;
    logic              rst_req;
    logic              rsto_n;
  } wdt_state_t;

  wdt_state_t st_r;
  wdt_state_t st_nxt;
  logic       tick;
  logic       service;

  // decode shared by the write and read paths
  function automatic logic [2:0] decode(input logic [ADDR_W-1:0] a);
    logic [2:0] r;
    r = {1'b0, REG_CTRL};
    case (a)
      OFS_CTRL:   r = {1'b1, REG_CTRL};
      OFS_CMD:    r = {1'b1, REG_CMD};
      OFS_STATUS: r = {1'b1, REG_STATUS};
      OFS_COUNT:  r = {1'b1, REG_COUNT};
      default:    r = {1'b0, REG_CTRL};
    endcase
    return r;
  endfunction

  wdt_prescaler u_pre (
    .clk     (clk),
    .rstn    (rstn),
    .sel     (st_r.psel),
    .restart (service),
    .tick    (tick)
  );

  // ==========================================================
  // command decode from the pending write
  logic       wr_go;
  logic [2:0] wr_dec;
  logic [2:0] rd_dec;
  logic       end_of_init_instruction;
  logic       supervisor_disable_instruction;
  logic       supervisor_enable_instruction;

  always_comb begin
    wr_go  = st_r.have_aw && st_r.have_w && !st_r.bvalid;
    wr_dec = decode(st_r.awaddr);
    rd_dec = decode(s_axi_araddr);
    service = 1'b0;
    end_of_init_instruction        = 1'b0;
    supervisor_disable_instruction = 1'b0;
    supervisor_enable_instruction  = 1'b0;
    if (wr_go && wr_dec[2] && (wr_dec[1:0] == REG_CMD) && st_r.wstrb[0]) begin
      service                        = st_r.wdata[CMD_SERVICE_BIT];
      supervisor_disable_instruction = st_r.wdata[CMD_DISABLE_BIT];
      supervisor_enable_instruction  = st_r.wdata[CMD_ENABLE_BIT];
      end_of_init_instruction        = st_r.wdata[CMD_INIT_END_BIT];
    end
  end

  // ==========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_req = 1'b0;

    // write address and data taken in either order
    st_nxt.awready = !st_r.have_aw && !st_r.bvalid;
    st_nxt.wready  = !st_r.have_w && !st_r.bvalid;
    if (s_axi_awvalid && st_r.awready) begin
      st_nxt.have_aw = 1'b1;
      st_nxt.awaddr  = s_axi_awaddr;
      st_nxt.awready = 1'b0;
    end
    if (s_axi_wvalid && st_r.wready) begin
      st_nxt.have_w  = 1'b1;
      st_nxt.wdata   = s_axi_wdata;
      st_nxt.wstrb   = s_axi_wstrb;
      st_nxt.wready  = 1'b0;
    end
    if (wr_go) begin
      st_nxt.have_aw = 1'b0;
      st_nxt.have_w  = 1'b0;
      st_nxt.bvalid  = 1'b1;
      st_nxt.awready = 1'b0;
      st_nxt.wready  = 1'b0;
      st_nxt.bresp   = wr_dec[2] ? RESP_OKAY : RESP_SLVERR;
      if (wr_dec[2] && (wr_dec[1:0] == REG_CTRL)) begin
        // mode is frozen once initialisation has ended
        if (st_r.wstrb[0] && !st_r.init_done) begin
          st_nxt.enh_mode = st_r.wdata[CTRL_ENH_BIT];
        end
        if (st_r.wstrb[0]) begin
          st_nxt.psel = st_r.wdata[CTRL_PSEL_LSB +: 2];
        end
        if (st_r.wstrb[1]) begin
          st_nxt.supervisor_reload_value = st_r.wdata[CTRL_RELOAD_LSB +: 8];
        end
      end
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end

    // read channel: one read at a time
    st_nxt.arready = !st_r.rvalid;
    if (s_axi_arvalid && st_r.arready) begin
      st_nxt.arready = 1'b0;
      st_nxt.rvalid  = 1'b1;
      st_nxt.rresp   = rd_dec[2] ? RESP_OKAY : RESP_SLVERR;
      st_nxt.rdata   = 32'h0000_0000;
      if (rd_dec[2]) begin
        case (reg_sel_t'(rd_dec[1:0]))
          REG_CTRL: begin
            st_nxt.rdata[CTRL_ENH_BIT]           = st_r.enh_mode;
            st_nxt.rdata[CTRL_PSEL_LSB +: 2]     = st_r.psel;
            st_nxt.rdata[CTRL_RELOAD_LSB +: 8]   = st_r.supervisor_reload_value;
          end
          REG_STATUS: begin
            st_nxt.rdata[ST_ENABLED_BIT]  = st_r.enabled;
            st_nxt.rdata[ST_INITDONE_BIT] = st_r.init_done;
            st_nxt.rdata[ST_OVF_BIT]      = st_r.ovf_seen;
            st_nxt.rdata[ST_ENH_BIT]      = st_r.enh_mode;
          end
          REG_COUNT: begin
            st_nxt.rdata[15:0] = st_r.cnt;
          end
          default: begin
            st_nxt.rdata = 32'h0000_0000;
          end
        endcase
      end
    end
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid  = 1'b0;
      st_nxt.arready = 1'b0;
    end

    // enable control
    if (supervisor_disable_instruction) begin
      if (st_r.enh_mode) begin
        st_nxt.enabled = 1'b0;
      end else if (!st_r.init_done) begin
        st_nxt.enabled = 1'b0;
      end
    end
    if (supervisor_enable_instruction && st_r.enh_mode) begin
      st_nxt.enabled = 1'b1;
    end
    if (end_of_init_instruction) begin
      st_nxt.init_done = 1'b1;
      st_nxt.rsto_n    = 1'b1;
    end

    // counter: service beats a tick in the same cycle
    if (service) begin
      st_nxt.cnt = {st_r.supervisor_reload_value, 8'h00};
    end else if (st_r.enabled && tick) begin
      st_nxt.cnt = st_r.cnt + 16'h0001;
      if (st_r.cnt == CNT_TOP) begin
        // one-cycle request; indication held low until the next end of init
        st_nxt.rst_req   = 1'b1;
        st_nxt.rsto_n    = 1'b0;
        st_nxt.ovf_seen  = 1'b1;
        st_nxt.init_done = 1'b0;
        st_nxt.cnt       = {st_r.supervisor_reload_value, 8'h00};
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r                         <= '0;
      st_r.enabled                 <= 1'b1;
      st_r.psel                    <= PSEL_RST;
      st_r.supervisor_reload_value <= RELOAD_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign s_axi_awready             = st_r.awready;
  assign s_axi_wready              = st_r.wready;
  assign s_axi_bvalid              = st_r.bvalid;
  assign s_axi_bresp               = st_r.bresp;
  assign s_axi_arready             = st_r.arready;
  assign s_axi_rvalid              = st_r.rvalid;
  assign s_axi_rresp               = st_r.rresp;
  assign s_axi_rdata               = st_r.rdata;
  assign hw_reset_req              = st_r.rst_req;
  assign reset_indication_output_n = st_r.rsto_n;

endmodule
`default_nettype wire

// ---- logic/wdt_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
module wdt_prescaler
  import wdt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [1:0] sel,
  input  wire logic       restart,
  output logic            tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } pre_state_t;

  pre_state_t st_r;
  pre_state_t st_nxt;

  function automatic logic [7:0] term_count(input logic [1:0] s);
    case (s)
      PSEL_DIV2:   term_count = TC_DIV2;
      PSEL_DIV4:   term_count = TC_DIV4;
      PSEL_DIV128: term_count = TC_DIV128;
      default:     term_count = TC_DIV256;
    endcase
  endfunction

  // ==========================================================
  // divider: one tick every 2/4/128/256 clocks
  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (restart) begin
      st_nxt.cnt = 8'h00;
    end else if (st_r.cnt >= term_count(sel)) begin
      st_nxt.cnt  = 8'h00;
      st_nxt.tick = 1'b1;
    end else begin
      st_nxt.cnt = st_r.cnt + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign tick = st_r.tick;

endmodule
`default_nettype wire

// ---- pkg/wdt_pkg.sv ----
// How it works
// - after reset the counter runs and is armed with no software action
// - compatible mode: disable only honoured before end of initialisation
// - enhanced mode: disable and enable commands work at any time
// - overflow while enabled pulses internal reset and pulls reset indication low
// - 16-bit counter ticks at system clock divided by 2, 4, 128 or 256
// - software sets a reload value for the counter's upper byte
// - service loads upper byte from reload value and clears lower byte
// - reset defaults: divide by 2, reload zero, 3.28 ms at 40 MHz
`default_nettype none
package wdt_pkg;

  // ==========================================================
  // bus and register map
  localparam int         ADDR_W       = 4;
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_CMD      = 4'h4;
  localparam logic [3:0] OFS_STATUS   = 4'h8;
  localparam logic [3:0] OFS_COUNT    = 4'hC;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;

  // ==========================================================
  // field positions
  localparam int CTRL_ENH_BIT   = 0;
  localparam int CTRL_PSEL_LSB  = 1;
  localparam int CTRL_RELOAD_LSB = 8;
  localparam int CMD_SERVICE_BIT = 0;
  localparam int CMD_DISABLE_BIT = 1;
  localparam int CMD_ENABLE_BIT  = 2;
  localparam int CMD_INIT_END_BIT = 3;
  localparam int ST_ENABLED_BIT  = 0;
  localparam int ST_INITDONE_BIT = 1;
  localparam int ST_OVF_BIT      = 2;
  localparam int ST_ENH_BIT      = 3;

  // ==========================================================
  // reset values and counts
  localparam logic [1:0]  PSEL_DIV2   = 2'h0;
  localparam logic [1:0]  PSEL_DIV4   = 2'h1;
  localparam logic [1:0]  PSEL_DIV128 = 2'h2;
  localparam logic [1:0]  PSEL_DIV256 = 2'h3;
  localparam logic [1:0]  PSEL_RST    = PSEL_DIV2;
  localparam logic [7:0]  RELOAD_RST  = 8'h00;
  localparam logic [7:0]  TC_DIV2     = 8'h01;
  localparam logic [7:0]  TC_DIV4     = 8'h03;
  localparam logic [7:0]  TC_DIV128   = 8'h7F;
  localparam logic [7:0]  TC_DIV256   = 8'hFF;
  localparam logic [15:0] CNT_TOP     = 16'hFFFF;

  typedef enum logic [1:0] {
    REG_CTRL   = 2'h0,
    REG_CMD    = 2'h1,
    REG_STATUS = 2'h3,
    REG_COUNT  = 2'h2
  } reg_sel_t;

endpackage
`default_nettype wire
